/* File: core/flash_regs.svh */
// named constants of the flash instruction decoder and its host end
// assumes inclusion by bare name from both ends and the bench
`ifndef FLASH_DEC_REGS_SVH
`define FLASH_DEC_REGS_SVH
// coded cycle data and instruction bytes
`define UNLOCK1_DATA   8'haa
`define UNLOCK2_DATA   8'h55
`define CMD_ID_READ    8'h90
`define CMD_PROGRAM    8'ha0
`define CMD_ERASE_SET  8'h80
`define CMD_SECT_ERASE 8'h30
`define CMD_BULK_ERASE 8'h10
`define CMD_BYPASS     8'h20
`define CMD_SUSPEND    8'hb0
`define CMD_RESUME     8'h30
`define CMD_RESET      8'hf0
`define CMD_BYP_RST1   8'h90
`define CMD_BYP_RST2   8'h00
// low twelve address bits of the coded cycles
`define SLOT0_ADDR16   12'haaa
`define SLOT1_ADDR16   12'h554
`define SLOT0_ADDR8    12'h555
`define SLOT1_ADDR8    12'haaa
// identifier and protection read locations, low address byte
`define ID_ADDR16      8'h02
`define PROT_ADDR16    8'h04
`define ID_ADDR8       8'h01
`define PROT_ADDR8     8'h02
// identifier value, arbitrary neutral value
`define MAIN_ID_VALUE  16'h005a
// gap between instruction bytes and sector append window
`define CLK_MHZ        25
`define GAP_US         80
`define GAP_CYCLES     (`GAP_US * `CLK_MHZ)
// host strobe timing in clock cycles
`define WR_LOW_CYC     3'h2
`define RD_LOW_CYC     3'h4
`define HIGH_CYC       3'h2
`endif

/* File: core/flash_dec_pkg.sv */
// types shared by the flash decoder device end and host end
// assumes flash_regs.svh sits beside it
package flash_dec_pkg;
    // decoder states
    typedef enum logic [3:0] {
        ST_READ, ST_UNLK1, ST_UNLK2, ST_ID, ST_PROG, ST_ERS1, ST_ERS2, ST_ERS3,
        ST_ERSAPP, ST_ERASING, ST_BULK, ST_SUSP, ST_BYP, ST_BYPPROG, ST_BYPRST
    } dec_state_type;

    typedef struct packed {
        dec_state_type st;
        dec_state_type home;
        logic [10:0]   cnt;
        logic          wrPrev;
        logic          rdPrev;
        logic          sel;
        logic          selMain;
        logic [15:0]   latchAddr;
        logic          rdPend;
        logic          rdMain;
        logic [15:0]   rdata;
        logic [15:0]   arrayAddr;
        logic          arrayRd;
        logic          progReq;
        logic [15:0]   progAddr;
        logic [15:0]   progWord;
        logic          progMain;
        logic          sectorAdd;
        logic          eraseStart;
        logic          bulkErase;
        logic          suspendReq;
        logic          resumeReq;
    } dec_regs_type;

    // host bus cycle engine
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} host_state_type;

    typedef struct packed {
        host_state_type st;
        logic [2:0]     cnt;
        logic [1:0]     seq;
        logic [1:0]     kind;
        logic [15:0]    addr;
        logic [15:0]    data;
        logic           wrStrobeN;
        logic           rdStrobeN;
        logic [15:0]    busAddr;
        logic [15:0]    busData;
        logic [15:0]    mainSel;
        logic [3:0]     bootSel;
        logic [15:0]    mSelReq;
        logic [3:0]     bSelReq;
        logic           ready;
        logic           rspValid;
        logic [15:0]    rspData;
    } host_regs_type;

    // request kinds on the host user port
    localparam logic [1:0] KIND_WRITE  = 2'h0;
    localparam logic [1:0] KIND_READ   = 2'h1;
    localparam logic [1:0] KIND_UNLOCK = 2'h2;
endpackage

/* File: core/flash_bus_if.sv */
// parallel memory bus between host microcontroller and flash decoder
// assumes both ends run on one clock; all pins synchronous
`timescale 1ns/10ps
interface flash_bus_if;
    logic        wrStrobeN;   // write strobe, active low
    logic        rdStrobeN;   // read strobe, active low
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] mainSectorSelects;
    logic [3:0]  bootSectorSelects;
    logic        byteMode;    // 1 selects the 8-bit bus arrangement

    modport dev  (input wrStrobeN, rdStrobeN, addr, wdata, mainSectorSelects,
                  bootSectorSelects, byteMode, output rdata);
    modport host (output wrStrobeN, rdStrobeN, addr, wdata, mainSectorSelects,
                  bootSectorSelects, input rdata, byteMode);
endinterface

/* File: core/flash_decoder_dev.sv */
// flash instruction decoder, device end of the parallel bus
// assumes pins synchronous to clk; array, protection and erase engine on user side
`timescale 1ns/10ps
`include "flash_regs.svh"

// Function
// [RULE_01] two coded cycles open each unlocked instruction
// [RULE_02] bad byte or long gap returns home; in the sector append window a non-30h byte starts the erase instead
// [RULE_03] sector selects pick main or boot array
// [RULE_04] instruction cycles are writes except reads
// [RULE_05] host writes command bytes to even addresses; in byte mode the first coded and command address is 555h
// [RULE_06] address at strobe fall, data at rise
// [RULE_07] only low twelve address bits decode
// [RULE_08] read mode returns array data directly
// [RULE_09] F0h returns to read mode; code returns home, ignores it in bypass and in an erase without error flag
// [RULE_10] protection read returns 01h or 00h
// [RULE_11] appended 30h sectors within 80us join
// [RULE_12] B0h suspends only a running sector erase
// [RULE_13] suspended erase allows reads, programs, ID reads
// [RULE_14] 30h resumes only a suspended erase
// [RULE_15] host never commands array it executes from
// [RULE_16] bypass program only after bypass entry
// [RULE_17] 90h then 00h leaves bypass mode
// [RULE_18] third byte selects the instruction
// [RULE_19] explicit state decides which instructions apply
module flash_decoder_dev (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // bus pins
    flash_bus_if.dev                     bus,
    // array read port
    output logic [15:0]                  arrayAddr,
    output logic                         arrayRd,
    input  wire logic [15:0]             arrayData,
    input  wire logic                    sectorProtected,
    input  wire logic                    sectorErasing,
    // embedded algorithm commands
    output logic                         progReq,
    output logic [15:0]                  progAddr,
    output logic [15:0]                  progWord,
    output logic                         progMain,
    output logic                         sectorAdd,
    output logic                         eraseStart,
    output logic                         bulkErase,
    output logic                         suspendReq,
    output logic                         resumeReq,
    input  wire logic                    eraseDone,
    input  wire logic                    errorFlagBit,
    // decoder state
    output flash_dec_pkg::dec_state_type mode
);
    flash_dec_pkg::dec_regs_type q;
    flash_dec_pkg::dec_regs_type d;

    // slot 0 is the first coded and command address, slot 1 the second
    function automatic logic atSlot(input logic [11:0] a, input logic bm, input logic slot);
        logic [11:0] ref0;
        ref0 = slot ? (bm ? `SLOT1_ADDR8 : `SLOT1_ADDR16)
                    : (bm ? `SLOT0_ADDR8 : `SLOT0_ADDR16);
        return a == ref0;
    endfunction

    function automatic logic intermediate(input flash_dec_pkg::dec_state_type s);
        return !(s inside {flash_dec_pkg::ST_READ, flash_dec_pkg::ST_ID,
            flash_dec_pkg::ST_SUSP, flash_dec_pkg::ST_ERASING, flash_dec_pkg::ST_BULK,
            flash_dec_pkg::ST_BYP});
    endfunction

    logic        wrFall;
    logic        wrRise;
    logic        rdFall;
    logic        selNow;
    logic [11:0] lowA;
    logic [7:0]  dat;
    logic        bm;
    logic        running;

    assign wrFall = q.wrPrev & ~bus.wrStrobeN;
    assign wrRise = ~q.wrPrev & bus.wrStrobeN;
    assign rdFall = q.rdPrev & ~bus.rdStrobeN;
    assign selNow = (|bus.mainSectorSelects) | (|bus.bootSectorSelects); // RULE_03
    assign lowA   = q.latchAddr[11:0]; // RULE_07
    assign dat    = bus.wdata[7:0];
    assign bm     = bus.byteMode;
    assign running = q.st inside {flash_dec_pkg::ST_ERASING, flash_dec_pkg::ST_BULK};

    // next state of the decoder
    always_comb begin
        d = q;
        d.wrPrev     = bus.wrStrobeN;
        d.rdPrev     = bus.rdStrobeN;
        d.arrayRd    = 1'b0;
        d.rdPend     = 1'b0;
        d.progReq    = 1'b0;
        d.sectorAdd  = 1'b0;
        d.eraseStart = 1'b0;
        d.bulkErase  = 1'b0;
        d.suspendReq = 1'b0;
        d.resumeReq  = 1'b0;

        // address and select taken at strobe fall
        if (wrFall) begin
            d.latchAddr = bus.addr; // RULE_06
            d.sel       = selNow;
            d.selMain   = |bus.mainSectorSelects; // RULE_03
        end

        // gap timer between instruction bytes
        d.cnt = intermediate(q.st) ? q.cnt + 11'h001 : 11'h000;
        if (intermediate(q.st) && q.cnt == 11'(`GAP_CYCLES - 1)) begin
            d.cnt = 11'h000;
            case (q.st)
                flash_dec_pkg::ST_ERSAPP: begin
                    d.st         = flash_dec_pkg::ST_ERASING; // RULE_11
                    d.eraseStart = 1'b1;
                end
                flash_dec_pkg::ST_BYPPROG,
                flash_dec_pkg::ST_BYPRST: d.st = flash_dec_pkg::ST_BYP;
                default: d.st = q.home; // RULE_02
            endcase
        end

        // erase engine finished: back to read mode
        if (running && eraseDone) begin
            d.st   = flash_dec_pkg::ST_READ;
            d.home = flash_dec_pkg::ST_READ;
        end

        // data taken and decoded at strobe rise; unselected writes are ignored
        if (wrRise && q.sel) begin
            d.cnt = 11'h000;
            case (q.st) // RULE_19
                flash_dec_pkg::ST_READ,
                flash_dec_pkg::ST_SUSP: begin
                    if (dat == `UNLOCK1_DATA && atSlot(lowA, bm, 1'b0)) begin
                        d.st = flash_dec_pkg::ST_UNLK1; // RULE_01
                    end else if (q.st == flash_dec_pkg::ST_SUSP && dat == `CMD_RESUME) begin
                        d.st        = flash_dec_pkg::ST_ERASING; // RULE_14
                        d.home      = flash_dec_pkg::ST_READ;
                        d.resumeReq = 1'b1;
                    end
                end
                flash_dec_pkg::ST_UNLK1: begin
                    if (dat == `UNLOCK2_DATA && atSlot(lowA, bm, 1'b1)) begin
                        d.st = flash_dec_pkg::ST_UNLK2; // RULE_01
                    end else begin
                        d.st = q.home; // RULE_02
                    end
                end
                flash_dec_pkg::ST_UNLK2: begin
                    d.st = q.home; // RULE_02
                    if (atSlot(lowA, bm, 1'b0)) begin
                        case (dat) // RULE_18
                            `CMD_ID_READ: d.st = flash_dec_pkg::ST_ID; // RULE_13
                            `CMD_PROGRAM: d.st = flash_dec_pkg::ST_PROG;
                            `CMD_ERASE_SET: begin
                                if (q.home == flash_dec_pkg::ST_READ) d.st = flash_dec_pkg::ST_ERS1;
                            end
                            `CMD_BYPASS: begin
                                if (q.home == flash_dec_pkg::ST_READ) begin
                                    d.st   = flash_dec_pkg::ST_BYP;
                                    d.home = flash_dec_pkg::ST_BYP;
                                end
                            end
                            default: d.st = q.home;
                        endcase
                    end
                end
                flash_dec_pkg::ST_PROG,
                flash_dec_pkg::ST_BYPPROG: begin
                    // a suspended erase blocks programs into the erasing sector
                    if (!(q.home == flash_dec_pkg::ST_SUSP && sectorErasing)) begin // RULE_13
                        d.progReq  = 1'b1;
                        d.progAddr = q.latchAddr; // RULE_06
                        d.progWord = bus.wdata; // RULE_06
                        d.progMain = q.selMain;
                    end
                    d.st = (q.st == flash_dec_pkg::ST_BYPPROG) ? flash_dec_pkg::ST_BYP : q.home;
                end
                flash_dec_pkg::ST_ERS1: begin
                    d.st = (dat == `UNLOCK1_DATA && atSlot(lowA, bm, 1'b0))
                           ? flash_dec_pkg::ST_ERS2 : q.home;
                end
                flash_dec_pkg::ST_ERS2: begin
                    d.st = (dat == `UNLOCK2_DATA && atSlot(lowA, bm, 1'b1))
                           ? flash_dec_pkg::ST_ERS3 : q.home;
                end
                flash_dec_pkg::ST_ERS3: begin
                    if (dat == `CMD_SECT_ERASE) begin
                        d.st        = flash_dec_pkg::ST_ERSAPP;
                        d.sectorAdd = 1'b1;
                    end else if (dat == `CMD_BULK_ERASE && atSlot(lowA, bm, 1'b0)) begin
                        d.st        = flash_dec_pkg::ST_BULK;
                        d.bulkErase = 1'b1;
                    end else begin
                        d.st = q.home; // RULE_02
                    end
                end
                flash_dec_pkg::ST_ERSAPP: begin
                    if (dat == `CMD_SECT_ERASE) begin
                        d.sectorAdd = 1'b1; // RULE_11
                    end else begin
                        d.st         = flash_dec_pkg::ST_ERASING;
                        d.eraseStart = 1'b1;
                    end
                end
                flash_dec_pkg::ST_ERASING: begin
                    if (dat == `CMD_SUSPEND) begin
                        d.st         = flash_dec_pkg::ST_SUSP; // RULE_12
                        d.home       = flash_dec_pkg::ST_SUSP;
                        d.suspendReq = 1'b1;
                    end
                end
                flash_dec_pkg::ST_BYP: begin
                    if (dat == `CMD_PROGRAM) d.st = flash_dec_pkg::ST_BYPPROG; // RULE_16
                    if (dat == `CMD_BYP_RST1) d.st = flash_dec_pkg::ST_BYPRST; // RULE_17
                end
                flash_dec_pkg::ST_BYPRST: begin
                    if (dat == `CMD_BYP_RST2) begin
                        d.st   = flash_dec_pkg::ST_READ; // RULE_17
                        d.home = flash_dec_pkg::ST_READ;
                    end else begin
                        d.st = flash_dec_pkg::ST_BYP;
                    end
                end
                default: ;
            endcase
            // reset byte, honoured during an erase only once the error flag is up
            if (dat == `CMD_RESET && (!running || errorFlagBit) &&
                !(q.st inside {flash_dec_pkg::ST_BYP, flash_dec_pkg::ST_BYPPROG,
                               flash_dec_pkg::ST_BYPRST})) begin
                d.st = running ? flash_dec_pkg::ST_READ : q.home; // RULE_09
                if (d.st == flash_dec_pkg::ST_READ) d.home = flash_dec_pkg::ST_READ;
            end
        end

        // read cycle: fetch the array word, then choose the answer
        if (rdFall && selNow) begin
            d.arrayAddr = bus.addr; // RULE_08
            d.arrayRd   = 1'b1;
            d.rdPend    = 1'b1;
            d.rdMain    = |bus.mainSectorSelects;
        end
        if (q.rdPend) begin
            d.rdata = arrayData; // RULE_08
            if (q.st == flash_dec_pkg::ST_ID) begin
                if (q.arrayAddr[7:0] == (bm ? `ID_ADDR8 : `ID_ADDR16) && q.rdMain) begin
                    d.rdata = `MAIN_ID_VALUE;
                end else if (q.arrayAddr[7:0] == (bm ? `PROT_ADDR8 : `PROT_ADDR16)) begin
                    d.rdata = {15'h0000, sectorProtected}; // RULE_10
                end
            end
        end
    end

    // state register; reset lands in read mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q         <= '0;
            q.st      <= flash_dec_pkg::ST_READ;
            q.home    <= flash_dec_pkg::ST_READ;
            q.wrPrev  <= 1'b1;
            q.rdPrev  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.rdata  = q.rdata;
    assign arrayAddr  = q.arrayAddr;
    assign arrayRd    = q.arrayRd;
    assign progReq    = q.progReq;
    assign progAddr   = q.progAddr;
    assign progWord   = q.progWord;
    assign progMain   = q.progMain;
    assign sectorAdd  = q.sectorAdd;
    assign eraseStart = q.eraseStart;
    assign bulkErase  = q.bulkErase;
    assign suspendReq = q.suspendReq;
    assign resumeReq  = q.resumeReq;
    assign mode       = q.st;
endmodule

/* File: core/flash_host_ctl.sv */
// host end: turns user requests into strobed bus cycles
// assumes one request at a time, taken while reqReady is high
`timescale 1ns/10ps
`include "flash_regs.svh"
module flash_host_ctl (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // bus pins
    flash_bus_if.host        bus,
    // user request
    input  wire logic        reqValid,
    input  wire logic [1:0]  reqKind,
    input  wire logic [15:0] reqAddr,
    input  wire logic [15:0] reqData,
    input  wire logic [15:0] reqMainSel,
    input  wire logic [3:0]  reqBootSel,
    output logic             reqReady,
    // user answer
    output logic             rspValid,
    output logic [15:0]      rspData
);
    flash_dec_pkg::host_regs_type q;
    flash_dec_pkg::host_regs_type d;

    // one bus cycle: strobe low, then a high gap
    always_comb begin
        d = q;
        d.rspValid = 1'b0;
        case (q.st)
            flash_dec_pkg::H_IDLE: begin
                if (reqValid) begin
                    d.kind    = reqKind;
                    d.addr    = reqAddr;
                    d.data    = reqData;
                    d.mainSel = reqMainSel;
                    d.bootSel = reqBootSel;
                    d.ready   = 1'b0;
                    d.cnt     = 3'h0;
                    d.st      = flash_dec_pkg::H_LOW;
                    // unlocked writes open with the two coded cycles
                    if (reqKind == flash_dec_pkg::KIND_UNLOCK) begin // RULE_01
                        d.seq       = 2'h0;
                        d.busAddr   = {4'h0, bus.byteMode ? `SLOT0_ADDR8 : `SLOT0_ADDR16};
                        d.busData   = {8'h00, `UNLOCK1_DATA};
                        d.wrStrobeN = 1'b0;
                    end else begin
                        d.seq       = 2'h2;
                        d.busAddr   = reqAddr;
                        d.busData   = reqData;
                        d.wrStrobeN = (reqKind == flash_dec_pkg::KIND_READ); // RULE_04
                        d.rdStrobeN = (reqKind != flash_dec_pkg::KIND_READ);
                    end
                end
            end
            flash_dec_pkg::H_LOW: begin
                d.cnt = q.cnt + 3'h1;
                if (!q.rdStrobeN && q.cnt == `RD_LOW_CYC - 3'h1) begin
                    d.rspData   = bus.rdata; // last cycle of the read strobe
                    d.rspValid  = 1'b1;
                    d.rdStrobeN = 1'b1;
                    d.cnt       = 3'h0;
                    d.st        = flash_dec_pkg::H_HIGH;
                end else if (!q.wrStrobeN && q.cnt == `WR_LOW_CYC - 3'h1) begin
                    d.wrStrobeN = 1'b1;
                    d.cnt       = 3'h0;
                    d.st        = flash_dec_pkg::H_HIGH;
                end
            end
            flash_dec_pkg::H_HIGH: begin
                d.cnt = q.cnt + 3'h1;
                if (q.cnt == `HIGH_CYC - 3'h1) begin
                    d.cnt = 3'h0;
                    if (q.seq == 2'h2) begin
                        d.st      = flash_dec_pkg::H_IDLE;
                        d.ready   = 1'b1;
                        d.mainSel = 16'h0000;
                        d.bootSel = 4'h0;
                    end else begin
                        // next coded cycle, or the user's own write
                        d.seq       = q.seq + 2'h1;
                        d.wrStrobeN = 1'b0;
                        d.st        = flash_dec_pkg::H_LOW;
                        d.busAddr   = q.addr;
                        d.busData   = q.data;
                        if (q.seq == 2'h0) begin
                            d.busAddr = {4'h0, bus.byteMode ? `SLOT1_ADDR8 : `SLOT1_ADDR16};
                            d.busData = {8'h00, `UNLOCK2_DATA};
                        end
                    end
                end
            end
            default: d.st = flash_dec_pkg::H_IDLE;
        endcase
    end

    // bus pins idle high-strobed with no sector selected
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q           <= '0;
            q.st        <= flash_dec_pkg::H_IDLE;
            q.wrStrobeN <= 1'b1;
            q.rdStrobeN <= 1'b1;
            q.ready     <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.wrStrobeN         = q.wrStrobeN;
    assign bus.rdStrobeN         = q.rdStrobeN;
    assign bus.addr              = q.busAddr;
    assign bus.wdata             = q.busData;
    assign bus.mainSectorSelects = q.mainSel;
    assign bus.bootSectorSelects = q.bootSel;
    assign reqReady              = q.ready;
    assign rspValid              = q.rspValid;
    assign rspData               = q.rspData;
endmodule

/* File: test/flash_bus_checker.sv */
// bus checker for the flash decoder and its host end
// assumes the bench feeds it the interface signals on one clock
`timescale 1ns/10ps
module flash_bus_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // bus signals
    input wire logic        wrStrobeN,
    input wire logic        rdStrobeN,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic [15:0] mainSectorSelects,
    input wire logic [3:0]  bootSectorSelects
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // strobe widths, the device latches on both edges so widths matter
    property p_wlow; $fell(wrStrobeN) |-> ##1 !wrStrobeN ##1 wrStrobeN; endproperty
    a_wlow: assert property (p_wlow) else $error("write strobe width");
    property p_rlow; $fell(rdStrobeN) |-> ##1 !rdStrobeN [*3] ##1 rdStrobeN; endproperty
    a_rlow: assert property (p_rlow) else $error("read strobe width");
    property p_whi; $rose(wrStrobeN) |=> wrStrobeN; endproperty
    a_whi: assert property (p_whi) else $error("write strobe gap");
    property p_rhi; $rose(rdStrobeN) |=> rdStrobeN; endproperty
    a_rhi: assert property (p_rhi) else $error("read strobe gap");
    property p_excl; wrStrobeN || rdStrobeN; endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    // address and data held across the whole write strobe
    property p_hold; !wrStrobeN && $past(!wrStrobeN) |-> $stable({addr, wdata}); endproperty
    a_hold: assert property (p_hold) else $error("write cycle changed");
    property p_sel; $fell(wrStrobeN) |-> |{mainSectorSelects, bootSectorSelects}; endproperty
    a_sel: assert property (p_sel) else $error("write without select");
    // read answer moves only inside a read strobe
    property p_rd; $changed(rdata) |-> !rdStrobeN || $past(!rdStrobeN); endproperty
    a_rd: assert property (p_rd) else $error("read data moved");
    c_wr: cover property ($fell(wrStrobeN));
    c_rd: cover property ($fell(rdStrobeN));
    c_dat: cover property ($changed(rdata));
endmodule

/* File: test/tb_flash_instruction_decoder.sv */
// self-checking bench for the flash decoder and its host end
// assumes both ends meet in flash_bus_if on one clock
`timescale 1ns/10ps
`include "flash_regs.svh"
module tb_flash_instruction_decoder;
    logic clk = 0, arst_n = 0, reqValid = 0, eraseDone = 0, bm = 0;
    logic [1:0] reqKind = 0;
    logic [15:0] reqAddr = 0, reqData = 0, rspData, arrayAddr, progAddr, progWord, a, d;
    logic reqReady, rspValid, arrayRd;
    flash_dec_pkg::dec_state_type mode;
    int failures = 0, tests_run = 0;
    flash_bus_if bus();
    assign bus.byteMode = bm;
    // array model: word is address-derived, bit 12 marks a protected sector
    flash_decoder_dev u_flash_decoder_dev (.clk(clk), .arst_n(arst_n), .bus(bus),
        .arrayAddr(arrayAddr), .arrayRd(arrayRd), .arrayData(arrayAddr ^ 16'h5a5a),
        .sectorProtected(arrayAddr[12]), .sectorErasing(1'b0), .progReq(), .progAddr(progAddr),
        .progWord(progWord), .progMain(), .sectorAdd(), .eraseStart(), .bulkErase(),
        .suspendReq(), .resumeReq(), .eraseDone(eraseDone), .errorFlagBit(1'b0), .mode(mode));
    flash_host_ctl u_flash_host_ctl (.clk(clk), .arst_n(arst_n), .bus(bus), .reqValid(reqValid),
        .reqKind(reqKind), .reqAddr(reqAddr), .reqData(reqData), .reqMainSel(16'h0001),
        .reqBootSel(4'h0), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
    flash_bus_checker u_flash_bus_checker (.clk(clk), .arst_n(arst_n),
        .wrStrobeN(bus.wrStrobeN), .rdStrobeN(bus.rdStrobeN), .addr(bus.addr),
        .wdata(bus.wdata), .rdata(bus.rdata), .mainSectorSelects(bus.mainSectorSelects),
        .bootSectorSelects(bus.bootSectorSelects));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cm(input flash_dec_pkg::dec_state_type e);
        chk("mode", 16'(e), 16'(mode));
    endtask
    // one request, then wait for both ends to settle
    task automatic op(input logic [1:0] k, input logic [15:0] ad, input logic [15:0] dt);
        reqKind = k;
        reqAddr = ad;
        reqData = dt;
        reqValid = 1;
        @(negedge clk);
        reqValid = 0;
        repeat (2) @(negedge clk);
        repeat (30) if (reqReady !== 1'b1) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask
    task automatic wr(input logic [15:0] ad, input logic [7:0] b);
        op(flash_dec_pkg::KIND_WRITE, ad, {8'h00, b});
    endtask
    task automatic ul(input logic [15:0] ad, input logic [7:0] b);
        op(flash_dec_pkg::KIND_UNLOCK, ad, {8'h00, b});
    endtask
    task automatic rd(input logic [15:0] ad);
        op(flash_dec_pkg::KIND_READ, ad, 16'h0000);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    // watchdog, the run needs well under five thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results;
    end
    initial begin
        void'($urandom(32'h2f73));
        repeat (2) @(negedge clk);
        arst_n = 1;
        for (int w = 0; w < 2; w++) begin
            bm = w[0];
            a = $urandom;
            rd(a);
            chk("array", a ^ 16'h5a5a, rspData);
            a = {4'($urandom), bm ? `SLOT0_ADDR8 : `SLOT0_ADDR16};
            ul(a, `CMD_ID_READ);
            cm(flash_dec_pkg::ST_ID);
            rd({8'($urandom), bm ? `ID_ADDR8 : `ID_ADDR16});
            chk("ident", `MAIN_ID_VALUE, rspData);
            rd({8'h1f, bm ? `PROT_ADDR8 : `PROT_ADDR16});
            chk("protect", 16'h0001, rspData);
            wr(16'h0aaa, `CMD_RESET);
            cm(flash_dec_pkg::ST_READ);
            ul(a, 8'h77);
            cm(flash_dec_pkg::ST_READ);
            $display("test width %0d done", w);
        end
        bm = 0;
        a = $urandom & 16'hfffe;
        d = $urandom;
        ul(16'h0aaa, `CMD_PROGRAM);
        op(flash_dec_pkg::KIND_WRITE, a, d);
        chk("prog addr", a, progAddr);
        chk("prog word", d, progWord);
        $display("test program done");
        wr(a, `CMD_SUSPEND);
        cm(flash_dec_pkg::ST_READ);
        ul(16'h0aaa, `CMD_ERASE_SET);
        ul(16'h2000, `CMD_SECT_ERASE);
        wr(16'h4000, `CMD_SECT_ERASE);
        cm(flash_dec_pkg::ST_ERSAPP);
        repeat (2100) @(negedge clk);
        cm(flash_dec_pkg::ST_ERASING);
        wr(a, `CMD_SUSPEND);
        cm(flash_dec_pkg::ST_SUSP);
        wr(a, `CMD_RESUME);
        cm(flash_dec_pkg::ST_ERASING);
        eraseDone = 1;
        @(negedge clk);
        eraseDone = 0;
        repeat (2) @(negedge clk);
        cm(flash_dec_pkg::ST_READ);
        $display("test erase done");
        ul(16'h0aaa, `CMD_BYPASS);
        cm(flash_dec_pkg::ST_BYP);
        wr(a ^ 16'h0f00, `CMD_PROGRAM);
        op(flash_dec_pkg::KIND_WRITE, a, ~d);
        chk("bypass word", ~d, progWord);
        wr(16'h3000, `CMD_BYP_RST1);
        wr(16'h3000, `CMD_BYP_RST2);
        cm(flash_dec_pkg::ST_READ);
        $display("test bypass done");
        results;
    end
endmodule
